// [rtl/astc_top.sv]
// How it works
// - DMA mode: address step every N conversions
// - Otherwise interrupt every N conversions, N=field+1
// - Alternating fill, DMA mode off: slot 0, then slot 8
// - Plain fill always starts at slot 0
// - Alternate input: sets A and B take turns
// - Alternate input off: set A only
// - Half logic only in FIFO buffer mode
// - Clock source bit: RC or system, reset system
// - Flag shows sampling still running after disable
// - Charge pump bit, read/write, resets off
module astc_top #(
  parameter int ADDR_W = 5
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rc_clk_pin,
  input  wire logic              sample_enable,
  input  wire logic              sample_start,
  input  wire logic              conversion_done,
  output logic                   sample_time_done,
  output logic                   dma_address_step,
  output logic [3:0]             result_slot,
  output logic                   channel_set_b,
  output logic                   conv_clk_tick,
  output logic                   conversion_clock_source,
  output logic                   charge_pump_enable,
  output logic                   adc_irq
);

  if (ADDR_W < 5) begin : g_addr_check
    $error("ADDR_W must be at least 5");
  end

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;

  logic [15:0]       seq_q;
  logic [15:0]       tim_q;
  logic              dma_mode_enable_q;
  logic [2:0]        irq_status_q;
  logic [2:0]        irq_mask_q;
  logic [2:0]        irq_set;
  logic              buffer_half_status_q;
  logic [4:0]        conv_count_q;
  logic [4:0]        sample_count_q;
  logic              sampling_q;
  logic              rc_meta_q;
  logic              rc_sync_q;
  logic              rc_last_q;
  logic              sys_tick;
  logic              period_tick;
  logic              group_end;
  logic              fifo_alt;

  logic [4:0] events_per_interrupt_count;
  logic [4:0] auto_sample_time;
  logic [7:0] conversion_clock_divider;
  logic       buffer_fill_mode;
  logic       alternate_input_select;
  logic       buffer_register_mode;
  logic       extended_sampling_flag;

  assign events_per_interrupt_count =
    seq_q[astc_pkg::SEQ_COUNT_LO +: astc_pkg::COUNT_W];
  assign buffer_fill_mode       = seq_q[astc_pkg::SEQ_FILL_MODE];
  assign alternate_input_select = seq_q[astc_pkg::SEQ_ALT_INPUT];
  assign buffer_register_mode   = seq_q[astc_pkg::SEQ_BUFREG];
  assign auto_sample_time =
    tim_q[astc_pkg::TIM_STIME_LO +: astc_pkg::STIME_W];
  assign conversion_clock_divider =
    tim_q[astc_pkg::TIM_DIV_LO +: astc_pkg::DIV_W];

  // Halves only exist when the buffer runs as a FIFO
  assign fifo_alt = buffer_fill_mode & ~buffer_register_mode;
  assign group_end = conversion_done &
                     (conv_count_q == events_per_interrupt_count);
  assign extended_sampling_flag = sampling_q & ~sample_enable;

  astc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  // System derived conversion clock, divider+1 cycles per period
  astc_tick_div #(
    .DIV_W (astc_pkg::DIV_W)
  ) u_div (
    .sys_clk (sys_clk),
    .srst    (srst),
    .divide  (conversion_clock_divider),
    .tick    (sys_tick)
  );

  // RC clock arrives asynchronously; only rising edges are used as ticks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rc_meta_q <= 1'b0;
      rc_sync_q <= 1'b0;
      rc_last_q <= 1'b0;
    end else begin
      rc_meta_q <= rc_clk_pin;
      rc_sync_q <= rc_meta_q;
      rc_last_q <= rc_sync_q;
    end
  end

  assign period_tick = tim_q[astc_pkg::TIM_RCSRC] ?
                    (rc_sync_q & ~rc_last_q) : sys_tick;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_clk_tick           <= 1'b0;
      conversion_clock_source <= 1'b0;
      charge_pump_enable      <= 1'b0;
    end else begin
      conv_clk_tick           <= period_tick;
      conversion_clock_source <= tim_q[astc_pkg::TIM_RCSRC];
      charge_pump_enable      <= tim_q[astc_pkg::TIM_PUMP];
    end
  end

  // Register writes, byte lanes honoured; read-only bits masked
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seq_q             <= astc_pkg::SEQ_RESET;
      tim_q             <= astc_pkg::TIM_RESET;
      dma_mode_enable_q <= 1'b0;
      irq_mask_q        <= '0;
    end else if (wr_en) begin
      for (int b = 0; b < 2; b++) begin
        if (wr_strb[b]) begin
          if (wr_addr[4:0] == astc_pkg::OFF_SEQ_CTRL) begin
            seq_q[b*8 +: 8] <= wr_data[b*8 +: 8] &
                               astc_pkg::SEQ_WMASK[b*8 +: 8];
          end
          if (wr_addr[4:0] == astc_pkg::OFF_TIME_CTRL) begin
            tim_q[b*8 +: 8] <= wr_data[b*8 +: 8] &
                               astc_pkg::TIM_WMASK[b*8 +: 8];
          end
        end
      end
      if (wr_strb[0] && wr_addr[4:0] == astc_pkg::OFF_MODE_CTRL) begin
        dma_mode_enable_q <= wr_data[astc_pkg::MODE_DMA];
      end
      if (wr_strb[0] && wr_addr[4:0] == astc_pkg::OFF_IRQ_MASK) begin
        irq_mask_q <= wr_data[astc_pkg::IRQ_W-1:0];
      end
    end
  end

  // Conversion counter wraps after field+1 conversions
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_count_q <= '0;
    end else if (group_end) begin
      conv_count_q <= '0;
    end else if (conversion_done) begin
      conv_count_q <= conv_count_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dma_address_step <= 1'b0;
    end else begin
      dma_address_step <= group_end & dma_mode_enable_q;
    end
  end

  // Buffer half flips at each group interrupt in alternating FIFO fill
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      buffer_half_status_q <= 1'b0;
    end else if (!fifo_alt) begin
      buffer_half_status_q <= 1'b0;
    end else if (group_end && !dma_mode_enable_q) begin
      buffer_half_status_q <= ~buffer_half_status_q;
    end
  end

  // Write slot restarts at the active half base after each group; in DMA mode always at slot 0
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_slot <= astc_pkg::SLOT_LOW_HALF;
    end else if (group_end) begin
      if (fifo_alt && !dma_mode_enable_q && !buffer_half_status_q) begin
        result_slot <= astc_pkg::SLOT_HIGH_HALF;
      end else begin
        result_slot <= astc_pkg::SLOT_LOW_HALF;
      end
    end else if (conversion_done) begin
      result_slot <= result_slot + 1'b1;
    end
  end

  // Sampling timer counts conversion clock periods, at least one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sampling_q       <= 1'b0;
      sample_count_q   <= '0;
      sample_time_done <= 1'b0;
    end else begin
      sample_time_done <= 1'b0;
      if (sample_start && !sampling_q) begin
        sampling_q     <= 1'b1;
        sample_count_q <= auto_sample_time;
      end else if (sampling_q && period_tick) begin
        if (sample_count_q <= 5'h01) begin
          sampling_q       <= 1'b0;
          sample_time_done <= 1'b1;
        end else begin
          sample_count_q <= sample_count_q - 1'b1;
        end
      end
    end
  end

  // Input set choice advances with each finished sample while alternate input is on
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_set_b <= 1'b0;
    end else if (!alternate_input_select) begin
      channel_set_b <= 1'b0;
    end else if (sample_time_done) begin
      channel_set_b <= ~channel_set_b;
    end
  end

  assign irq_set[astc_pkg::IRQ_GROUP]  = group_end & ~dma_mode_enable_q;
  assign irq_set[astc_pkg::IRQ_DMA]    = group_end & dma_mode_enable_q;
  assign irq_set[astc_pkg::IRQ_SAMPLE] = sample_time_done;

  // Read clears, but a new event in the same cycle survives
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_status_q <= '0;
    end else if (rd_en && rd_addr[4:0] == astc_pkg::OFF_IRQ_STATUS) begin
      irq_status_q <= irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      adc_irq <= 1'b0;
    end else begin
      adc_irq <= |(irq_status_q & irq_mask_q);
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr[4:0])
      astc_pkg::OFF_SEQ_CTRL: begin
        rd_data[15:0] = seq_q;
        rd_data[astc_pkg::SEQ_HALF] = buffer_half_status_q;
      end
      astc_pkg::OFF_TIME_CTRL: begin
        rd_data[15:0] = tim_q;
        rd_data[astc_pkg::TIM_EXT] = extended_sampling_flag;
      end
      astc_pkg::OFF_MODE_CTRL: begin
        rd_data[astc_pkg::MODE_DMA] = dma_mode_enable_q;
      end
      astc_pkg::OFF_IRQ_STATUS: begin
        rd_data[astc_pkg::IRQ_W-1:0] = irq_status_q;
      end
      astc_pkg::OFF_IRQ_MASK: begin
        rd_data[astc_pkg::IRQ_W-1:0] = irq_mask_q;
      end
      astc_pkg::OFF_RUN_STATUS: begin
        rd_data[astc_pkg::RUN_HALF]     = buffer_half_status_q;
        rd_data[astc_pkg::RUN_CHAN_B]   = channel_set_b;
        rd_data[astc_pkg::RUN_SAMPLING] = sampling_q;
        rd_data[astc_pkg::RUN_SLOT_LO +: astc_pkg::SLOT_W] = result_slot;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

endmodule

// [rtl/astc_pkg.sv]
package astc_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_SEQ_CTRL   = 5'h00;
  localparam logic [4:0] OFF_TIME_CTRL  = 5'h04;
  localparam logic [4:0] OFF_MODE_CTRL  = 5'h08;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK   = 5'h10;
  localparam logic [4:0] OFF_RUN_STATUS = 5'h14;

  // Sequence control fields
  localparam int SEQ_ALT_INPUT = 0;
  localparam int SEQ_FILL_MODE = 1;
  localparam int SEQ_COUNT_LO  = 2;
  localparam int SEQ_HALF      = 7;
  localparam int SEQ_BUFREG    = 11;
  localparam logic [15:0] SEQ_WMASK = 16'h0800 | 16'h007F;

  // Timing control fields and register reset values
  localparam int TIM_DIV_LO    = 0;
  localparam int TIM_STIME_LO  = 8;
  localparam int TIM_PUMP      = 13;
  localparam int TIM_EXT       = 14;
  localparam int TIM_RCSRC     = 15;
  localparam logic [15:0] TIM_WMASK = 16'hBFFF;
  localparam logic [15:0] TIM_RESET = 16'h0000;
  localparam logic [15:0] SEQ_RESET = 16'h0000;

  // Mode control fields
  localparam int MODE_DMA      = 0;

  // Interrupt status and mask fields
  localparam int IRQ_GROUP     = 0;
  localparam int IRQ_DMA       = 1;
  localparam int IRQ_SAMPLE    = 2;
  localparam int IRQ_W         = 3;

  // Run status fields
  localparam int RUN_HALF      = 0;
  localparam int RUN_CHAN_B    = 1;
  localparam int RUN_SAMPLING  = 2;
  localparam int RUN_SLOT_LO   = 4;

  // Field widths and buffer geometry
  localparam int COUNT_W       = 5;
  localparam int STIME_W       = 5;
  localparam int DIV_W         = 8;
  localparam int SLOT_W        = 4;
  localparam logic [3:0] SLOT_LOW_HALF  = 4'h0;
  localparam logic [3:0] SLOT_HIGH_HALF = 4'h8;

  localparam logic [1:0] RESP_OKAY = 2'h0;

endpackage

// [rtl/astc_axil_slave.sv]
module astc_axil_slave #(
  parameter int ADDR_W = 5
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data
);

  logic aw_have_q;
  logic w_have_q;
  logic aw_take;
  logic w_take;
  logic ar_take;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_en   = ar_take;
  assign rd_addr = s_axi_araddr;

  // Address and data are taken independently, in either order
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~aw_take & ~s_axi_bvalid & ~wr_en;
      s_axi_wready  <= ~w_have_q & ~w_take & ~s_axi_bvalid & ~wr_en;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        wr_addr   <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wr_data  <= s_axi_wdata;
        wr_strb  <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  // One write strobe once both halves are held, then the response
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_en        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= astc_pkg::RESP_OKAY;
    end else begin
      wr_en <= aw_have_q & w_have_q & ~wr_en & ~s_axi_bvalid;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= astc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [rtl/astc_tick_div.sv]
module astc_tick_div #(
  parameter int DIV_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [DIV_W-1:0] divide,
  output logic                  tick
);

  if (DIV_W < 1) begin : g_width_check
    $error("DIV_W must be at least 1");
  end

  logic [DIV_W-1:0] count_q;

  // One tick every divide+1 clocks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else if (count_q >= divide) begin
      count_q <= '0;
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
      tick    <= 1'b0;
    end
  end

endmodule

// [sim/astc_top_sva.sv]
module astc_chk (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        conversion_done,
  input wire logic        sample_time_done,
  input wire logic        dma_address_step,
  input wire logic [3:0]  result_slot,
  input wire logic        channel_set_b,
  input wire logic        conversion_clock_source,
  input wire logic        charge_pump_enable,
  input wire logic        adc_irq
);
  default clocking dcb @(posedge sys_clk); endclocking

  a_reset_state_clear : assert property (
    srst |=> !conversion_clock_source && !charge_pump_enable && !adc_irq
      && result_slot == 4'h0)
    else $error("outputs not cleared by reset");
  a_step_needs_done : assert property (
    disable iff (srst) dma_address_step |-> $past(conversion_done))
    else $error("address step without a conversion");
  a_slot_advance : assert property (
    disable iff (srst) conversion_done |=> result_slot == $past(result_slot)
      + 4'h1 || result_slot == 4'h0 || result_slot == 4'h8)
    else $error("result slot moved to an illegal place");
  a_slot_hold : assert property (
    disable iff (srst) !conversion_done |=> $stable(result_slot))
    else $error("result slot moved without a conversion");
  a_chan_cause : assert property (
    disable iff (srst) !$stable(channel_set_b) |-> $past(sample_time_done))
    else $error("channel set changed outside a sample end");
  a_sample_pulse : assert property (
    disable iff (srst) sample_time_done |=> !sample_time_done)
    else $error("sample end pulse too long");
  a_read_latency : assert property (
    disable iff (srst) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_okay : assert property (
    disable iff (srst) s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
endmodule

bind astc_top astc_chk u_astc_chk (
  .sys_clk                 (sys_clk),
  .srst                    (srst),
  .s_axi_arvalid           (s_axi_arvalid),
  .s_axi_arready           (s_axi_arready),
  .s_axi_rvalid            (s_axi_rvalid),
  .s_axi_bvalid            (s_axi_bvalid),
  .s_axi_bresp             (s_axi_bresp),
  .conversion_done         (conversion_done),
  .sample_time_done        (sample_time_done),
  .dma_address_step        (dma_address_step),
  .result_slot             (result_slot),
  .channel_set_b           (channel_set_b),
  .conversion_clock_source (conversion_clock_source),
  .charge_pump_enable      (charge_pump_enable),
  .adc_irq                 (adc_irq)
);

// [sim/tb_astc_top.sv]
module tb_astc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, srst, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, rc_clk_pin;
  logic        sample_enable, sample_start, conversion_done, sample_time_done;
  logic        dma_address_step, channel_set_b, conv_clk_tick, src, pump, irq;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  result_slot;
  int          num_errors, compares, steps;

  astc_top u_astc_top (
    .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rc_clk_pin(rc_clk_pin),
    .sample_enable(sample_enable), .sample_start(sample_start),
    .conversion_done(conversion_done), .sample_time_done(sample_time_done),
    .dma_address_step(dma_address_step), .result_slot(result_slot),
    .channel_set_b(channel_set_b), .conv_clk_tick(conv_clk_tick),
    .conversion_clock_source(src), .charge_pump_enable(pump),
    .adc_irq(irq));

  always #2 sys_clk = ~sys_clk;
  // Pin toggles in step with sys_clk so tick spacing is exact
  always begin
    repeat (5) @(posedge sys_clk);
    rc_clk_pin <= ~rc_clk_pin;
  end
  always @(posedge sys_clk) if (dma_address_step === 1'b1) steps <= steps + 1;

  task finish_test;
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    int t;
    @(posedge sys_clk);
    awaddr <= a; awvalid <= 1'b1; bready <= 1'b1;
    wdata <= {16'h0000, d}; wvalid <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 100);
    bready <= 1'b0;
    if (t >= 100) chk("write_timeout", 0, 1);
  endtask

  task rd(input logic [4:0] a, output logic [15:0] d);
    int t;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 100);
    d = rdata[15:0];
    chk("rresp", 32'h0000_0000, rresp);
    rready <= 1'b0;
    if (t >= 100) chk("read_timeout", 0, 1);
  endtask

  // Back-to-back pulses: the hardest spacing the contract allows
  task conv(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      conversion_done <= 1'b1;
    end
    @(posedge sys_clk);
    conversion_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task smp(output int c);
    @(posedge sys_clk);
    sample_start <= 1'b1;
    @(posedge sys_clk);
    sample_start <= 1'b0;
    c = 1;
    while (sample_time_done !== 1'b1 && c < 9000) begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 9000) chk("sample_timeout", 0, 1);
    repeat (2) @(posedge sys_clk);
  endtask

  task gap(output int g);
    int t;
    t = 0;
    do begin @(posedge sys_clk); t++; end
    while (conv_clk_tick !== 1'b1 && t < 300);
    g = 0;
    do begin @(posedge sys_clk); g++; end
    while (conv_clk_tick !== 1'b1 && g < 300);
  endtask

  task t_regs;
    logic [15:0] d;
    rd(astc_pkg::OFF_TIME_CTRL, d); chk("time_rst", 16'h0000, d);
    chk("src_rst", 0, src);
    chk("pump_rst", 0, pump);
    wr(astc_pkg::OFF_TIME_CTRL, 16'hFFFF);
    rd(astc_pkg::OFF_TIME_CTRL, d); chk("time_rw", 16'hBFFF, d);
    chk("src_on", 1, src);
    chk("pump_on", 1, pump);
    wr(astc_pkg::OFF_TIME_CTRL, 16'h2000);
    repeat (2) @(posedge sys_clk);
    chk("src_off", 0, src);
    chk("pump_kept", 1, pump);
    rd(5'h18, d); chk("unmapped", 16'h0000, d);
  endtask

  task t_irq(input logic [4:0] f);
    logic [15:0] d;
    wr(astc_pkg::OFF_SEQ_CTRL, {9'h000, f, 2'b00});
    conv(int'(f));
    chk("irq_early", 0, irq);
    conv(1);
    chk("irq_due", 1, irq);
    rd(astc_pkg::OFF_IRQ_STATUS, d); chk("status", 16'h0001, d);
    repeat (3) @(posedge sys_clk);
    chk("irq_clear", 0, irq);
  endtask

  task t_dma;
    logic [15:0] d;
    wr(astc_pkg::OFF_IRQ_MASK, 16'h0000);
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0000);
    conv(1);
    chk("irq_masked", 0, irq);
    wr(astc_pkg::OFF_MODE_CTRL, 16'h0001);
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0008);
    rd(astc_pkg::OFF_IRQ_STATUS, d); chk("masked_st", 16'h0001, d);
    steps <= 0;
    conv(9); chk("steps_3rd", 3, steps);
    rd(astc_pkg::OFF_IRQ_STATUS, d); chk("dma_st", 16'h0002, d);
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0000);
    steps <= 0;
    conv(5); chk("steps_each", 5, steps);
    wr(astc_pkg::OFF_MODE_CTRL, 16'h0000);
    rd(astc_pkg::OFF_IRQ_STATUS, d);
    wr(astc_pkg::OFF_IRQ_MASK, 16'h0001);
  endtask

  task t_fill;
    logic [15:0] d;
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0006);
    conv(2); chk("slot_hi", 16'h8, result_slot);
    rd(astc_pkg::OFF_SEQ_CTRL, d); chk("half", 16'h0086, d);
    conv(1); chk("slot_9", 16'h9, result_slot);
    conv(1); chk("slot_lo", 16'h0, result_slot);
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0004);
    conv(2); chk("plain", 16'h0, result_slot);
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0806);
    conv(2); chk("bufreg", 16'h0, result_slot);
    rd(astc_pkg::OFF_IRQ_STATUS, d);
  endtask

  task t_sample;
    logic [15:0] d;
    logic        cb;
    int          c;
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0001);
    wr(astc_pkg::OFF_TIME_CTRL, 16'h1FFF);
    cb = channel_set_b;
    fork
      smp(c);
      begin
        rd(astc_pkg::OFF_TIME_CTRL, d); chk("ext_0", 16'h1FFF, d);
        @(posedge sys_clk);
        sample_enable <= 1'b0;
        rd(astc_pkg::OFF_TIME_CTRL, d); chk("ext_1", 16'h5FFF, d);
      end
    join
    chk("alt_b", !cb, channel_set_b);
    rd(astc_pkg::OFF_TIME_CTRL, d); chk("ext_end", 16'h1FFF, d);
    wr(astc_pkg::OFF_TIME_CTRL, 16'h0403);
    smp(c);
    chk("stime_lo", 1, c >= 13);
    chk("stime_hi", 1, c <= 20);
    chk("alt_a", cb, channel_set_b);
    wr(astc_pkg::OFF_SEQ_CTRL, 16'h0000);
    smp(c); chk("alt_off", cb, channel_set_b);
  endtask

  task t_tick;
    int g;
    wr(astc_pkg::OFF_TIME_CTRL, 16'h0003);
    gap(g); chk("tick_sys", 4, g);
    wr(astc_pkg::OFF_TIME_CTRL, 16'h8003);
    repeat (10) @(posedge sys_clk);
    gap(g); chk("tick_rc", 10, g);
    wr(astc_pkg::OFF_TIME_CTRL, 16'hA000);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk("src_rerst", 0, src);
    chk("pump_rerst", 0, pump);
  endtask

  initial begin
    sys_clk = 0; srst = 1; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    rc_clk_pin = 0; sample_enable = 1; sample_start = 0;
    conversion_done = 0; num_errors = 0; compares = 0;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs;
    wr(astc_pkg::OFF_IRQ_MASK, 16'h0001);
    t_irq(5'h00);
    t_irq(5'h01);
    t_irq(5'h1F);
    t_dma;
    t_fill;
    t_sample;
    t_tick;
    finish_test;
  end

  // Longest test is one 7936-cycle sample; this leaves wide margin
  initial begin
    #240000;
    num_errors++;
    finish_test;
  end
endmodule
